// *** rtl/lsd_pkg.sv ***
package lsd_pkg;

  // link shape
  localparam int LANES = 4;
  localparam int BITS_PER_LANE = 7;
  localparam int WORD_BITS = LANES * BITS_PER_LANE;

  // nominal strobe positions of the first and last bit at 75 MHz
  localparam real STROBE_FIRST_NS = 0.95;
  localparam real STROBE_LAST_NS = 12.38;

  // system clock rate
  localparam int SYS_CLK_MHZ = 100;
  localparam int SYS_CLK_PS = 10000;

  // sleep entry, longest time, rounded down
  localparam int SLEEP_ENTRY_US = 1;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * SYS_CLK_MHZ;

  // pll lock time, longest time, rounded down
  localparam int PLL_LOCK_MS = 10;
  localparam int PLL_LOCK_CYC = PLL_LOCK_MS * 1000 * SYS_CLK_MHZ;

  // clock-through delay, data to strobe edge, least time rounded up
  localparam int THRU_MIN_PS = 3400;
  localparam int THRU_MAX_PS = 7300;
  localparam int THRU_CYC = (THRU_MIN_PS + SYS_CLK_PS - 1) / SYS_CLK_PS;

  // high time of the output strobe clock
  localparam int STROBE_HIGH_CYC = 4;

  // link latency in link clock periods
  localparam int LINK_LATENCY_PERIODS = 2;

  // reset values
  localparam logic [WORD_BITS-1:0] WORD_RESET = 28'h000_0000;

  // output sequencer states
  typedef enum logic [2:0] {
    LSD_ST_SLEEP,
    LSD_ST_LOCK,
    LSD_ST_IDLE,
    LSD_ST_SETUP,
    LSD_ST_HIGH
  } lsd_state_e;

endpackage

// *** rtl/lsd_sync.sv ***
`timescale 1ns/100ps
// two-flop synchroniser, reset to zero
module lsd_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// *** rtl/lsd_lane_shift.sv ***
`timescale 1ns/100ps
// one lane: seven-bit shift register, first bit lands in bit 0
module lsd_lane_shift
  import lsd_pkg::*;
#(
  parameter int N = BITS_PER_LANE
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bit_in,
  output logic [N-1:0] bits_out
);
  // shift right, newest bit at the top
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bits_out <= '0;
    end else begin
      bits_out <= {bit_in, bits_out[N-1:1]};
    end
  end
endmodule

// *** rtl/lsd_deserializer.sv ***
`timescale 1ns/100ps
// four-lane seven-to-one deserialising receiver
module lsd_deserializer
  import lsd_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic link_bit_clk_in,
  input wire logic forwarded_link_clock_in,
  input wire logic [LANES-1:0] serial_lane_in,
  input wire logic [LANES-1:0] lane_float_in,
  input wire logic link_clock_float_in,
  input wire logic sleep_request_n_in,
  output logic [WORD_BITS-1:0] parallel_word_out,
  output logic parallel_strobe_clock_out,
  output logic lock_ready_out
);

  localparam int SLEEP_BOUND = SLEEP_ENTRY_CYC;
  localparam logic [2:0] THRU_LAST = 3'(THRU_CYC - 1);
  localparam logic [2:0] HIGH_LAST = 3'(STROBE_HIGH_CYC - 1);
  localparam logic [2:0] POS_LAST = 3'(BITS_PER_LANE - 1);

  // link domain
  logic [1:0] link_rst_q;
  logic link_rst_n;
  logic [2*LANES:0] link_pins_s;
  logic fwd_s;
  logic fwd_q;
  logic [LANES-1:0] lane_s;
  logic [LANES-1:0] lane_float_s;
  logic frame_start;
  logic frame_complete;
  logic [2:0] pos_q;
  logic [LANES-1:0] sampled_bit;
  logic [BITS_PER_LANE-1:0] lane_bits [LANES];
  logic [WORD_BITS-1:0] next_word;
  logic [WORD_BITS-1:0] word_hold;
  logic link_tog;

  // reset release synchronised to the link clock
  always_ff @(posedge link_bit_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_rst_q <= 2'b00;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_q[1];

  // pins into the link domain
  lsd_sync #(.W(2 * LANES + 1)) u_link_sync (
    .clk_in(link_bit_clk_in),
    .rst_n_in(link_rst_n),
    .async_in({forwarded_link_clock_in, lane_float_in, serial_lane_in}),
    .sync_out(link_pins_s)
  );
  assign fwd_s = link_pins_s[2*LANES];
  assign lane_float_s = link_pins_s[2*LANES-1:LANES];
  assign lane_s = link_pins_s[LANES-1:0];

  // forwarded clock edge history for frame detection
  always_ff @(posedge link_bit_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fwd_q <= 1'b0;
    end else begin
      fwd_q <= fwd_s;
    end
  end

  // strobe zero on forwarded clock rise
  assign frame_start = fwd_s & ~fwd_q;
  assign frame_complete = frame_start & (pos_q == POS_LAST);

  // bit position within the frame, saturates on a lost frame
  always_ff @(posedge link_bit_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pos_q <= 3'h7;
    end else if (frame_start) begin
      pos_q <= 3'h0;
    end else if (pos_q != 3'h7) begin
      pos_q <= pos_q + 3'h1;
    end
  end

  // per-lane sampling with failsafe and word mapping
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign sampled_bit[l] = lane_s[l] | lane_float_s[l];

      lsd_lane_shift #(.N(BITS_PER_LANE)) u_lane (
        .clk_in(link_bit_clk_in),
        .rst_n_in(link_rst_n),
        .bit_in(sampled_bit[l]),
        .bits_out(lane_bits[l])
      );

      // lane l owns word bits l*7 upward
      assign next_word[l*BITS_PER_LANE +: BITS_PER_LANE] = lane_bits[l];
    end
  endgenerate

  // capture the finished 28-bit word and flag it
  always_ff @(posedge link_bit_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      word_hold <= WORD_RESET;
      link_tog <= 1'b0;
    end else if (frame_complete) begin
      word_hold <= next_word;
      link_tog <= ~link_tog;
    end
  end

  // system domain
  logic [2:0] sys_pins_s;
  logic tog_s;
  logic tog_q;
  logic sleep_n_s;
  logic clk_float_s;
  logic asleep;
  logic new_word;
  logic [31:0] lock_cnt;
  logic locked;
  lsd_state_e state;
  lsd_state_e next_state;
  logic [2:0] phase_cnt;

  // toggle and pins into the system domain
  lsd_sync #(.W(3)) u_sys_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(reset_n_in),
    .async_in({link_tog, sleep_request_n_in, link_clock_float_in}),
    .sync_out(sys_pins_s)
  );
  assign tog_s = sys_pins_s[2];
  assign sleep_n_s = sys_pins_s[1];
  assign clk_float_s = sys_pins_s[0];
  assign asleep = ~sleep_n_s;

  // toggle edge marks a stable word in word_hold
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_s;
    end
  end
  assign new_word = tog_s ^ tog_q;

  // lock timer restarts on sleep or lost clock
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_cnt <= 32'h0000_0000;
    end else if (asleep || clk_float_s) begin
      lock_cnt <= 32'h0000_0000;
    end else if (lock_cnt != 32'(LOCK_CYCLES)) begin
      lock_cnt <= lock_cnt + 32'h0000_0001;
    end
  end
  assign locked = (lock_cnt == 32'(LOCK_CYCLES));

  // output sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      LSD_ST_SLEEP: begin
        next_state = LSD_ST_LOCK;
      end
      LSD_ST_LOCK: begin
        if (locked) begin
          next_state = LSD_ST_IDLE;
        end
      end
      LSD_ST_IDLE: begin
        if (new_word) begin
          next_state = LSD_ST_SETUP;
        end
      end
      LSD_ST_SETUP: begin
        if (phase_cnt == THRU_LAST) begin
          next_state = LSD_ST_HIGH;
        end
      end
      LSD_ST_HIGH: begin
        if (phase_cnt == HIGH_LAST) begin
          next_state = LSD_ST_IDLE;
        end
      end
      default: begin
        next_state = LSD_ST_SLEEP;
      end
    endcase
    // lost link clock stops the strobe
    if (clk_float_s && state != LSD_ST_SLEEP) begin
      next_state = LSD_ST_LOCK;
    end
    if (asleep) begin
      next_state = LSD_ST_SLEEP;
    end
  end

  // state and phase counter
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= LSD_ST_SLEEP;
      phase_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        phase_cnt <= 3'h0;
      end else begin
        phase_cnt <= phase_cnt + 3'h1;
      end
    end
  end

  // data leads the strobe by the clock-through delay
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      parallel_word_out <= WORD_RESET;
    end else if (asleep) begin
      parallel_word_out <= WORD_RESET;
    end else if (next_state == LSD_ST_SETUP && state == LSD_ST_IDLE) begin
      parallel_word_out <= word_hold;
    end
  end

  // strobe high only in the high phase
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      parallel_strobe_clock_out <= 1'b0;
      lock_ready_out <= 1'b0;
    end else begin
      parallel_strobe_clock_out <= (next_state == LSD_ST_HIGH);
      lock_ready_out <= locked && !asleep && !clk_float_s;
    end
  end

  // assertions on the output side and the frame logic
  AST_SLEEP_LOW: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    asleep |=> (parallel_word_out == WORD_RESET) && !parallel_strobe_clock_out
  ) else $error("outputs not low during sleep");

  AST_SLEEP_ENTRY: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(sleep_request_n_in) |-> ##[1:SLEEP_BOUND]
      ((parallel_word_out == WORD_RESET) && !parallel_strobe_clock_out)
  ) else $error("sleep entry too slow");

  AST_SLEEP_STAYS: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    asleep && $past(asleep) |-> parallel_word_out == WORD_RESET
  ) else $error("word left nonzero while asleep");

  AST_STROBE_STABLE: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(parallel_strobe_clock_out) |-> $stable(parallel_word_out)
  ) else $error("data moved at strobe rise");

  AST_STROBE_WIDTH: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(parallel_strobe_clock_out)
      |-> (parallel_strobe_clock_out || state == LSD_ST_SLEEP
        || state == LSD_ST_LOCK)[*4] ##1 !parallel_strobe_clock_out
  ) else $error("strobe high time wrong");

  AST_THRU_DELAY: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    state == LSD_ST_IDLE && new_word && !asleep && !clk_float_s
      |=> !parallel_strobe_clock_out ##1
        (parallel_strobe_clock_out || asleep || clk_float_s)
  ) else $error("strobe not one cycle after data");

  AST_LOCK_GATE: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !locked |=> !parallel_strobe_clock_out
  ) else $error("strobe before lock");

  AST_FLOAT_CLK_LOW: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_float_s |=> !parallel_strobe_clock_out
  ) else $error("strobe active with floating clock");

  AST_FLOAT_HOLD: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_float_s && !asleep |=> $stable(parallel_word_out)
  ) else $error("data changed with floating clock");

  AST_LANE_FAILSAFE: assert property (
    @(posedge link_bit_clk_in) disable iff (!link_rst_n)
    lane_float_s[0] |=> lane_bits[0][BITS_PER_LANE-1]
  ) else $error("floating lane not read high");

  AST_FRAME_FLAG: assert property (
    @(posedge link_bit_clk_in) disable iff (!link_rst_n)
    frame_complete |=> (link_tog != $past(link_tog)) && (pos_q == 3'h0)
  ) else $error("full frame not flagged");

  COV_WORD: cover property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(parallel_strobe_clock_out)
  );
  COV_SLEEP: cover property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(sleep_n_s) ##[1:8] parallel_word_out == WORD_RESET
  );
  COV_FLOAT: cover property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    locked ##1 clk_float_s
  );
endmodule

// *** bench/lsd_tx_model.sv ***
`timescale 1ns/100ps
// serialising transmitter: one word per frame of seven bit clocks
module lsd_tx_model
  import lsd_pkg::*;
(
  input wire logic bit_clk_in,
  input wire logic [WORD_BITS-1:0] word_in,
  output logic frame_clk_out,
  output logic [LANES-1:0] lane_out
);
  int slot;

  // start idle and low so nothing unknown reaches the receiver
  initial begin
    slot = 0;
    frame_clk_out = 1'b0;
    lane_out = 4'h0;
  end

  // lane l bit b is word bit l*7+b
  // frame clock rises with bit 0, high for bits 0 to 3
  always @(negedge bit_clk_in) begin
    frame_clk_out <= (slot < 4);
    for (int l = 0; l < LANES; l++) begin
      lane_out[l] <= word_in[l*BITS_PER_LANE+slot];
    end
    slot <= (slot == BITS_PER_LANE - 1) ? 0 : slot + 1;
  end
endmodule

// *** bench/lsd_deserializer_test.sv ***
`timescale 1ns/100ps
module lsd_deserializer_test;
  import lsd_pkg::*;
  localparam int LOCK_N = 20;
  logic sys_clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n_in = 1'b1;
  logic [LANES-1:0] lane_float = 4'h0;
  logic clk_float = 1'b0;
  logic sleep_n = 1'b0;
  logic [WORD_BITS-1:0] tx_word = 28'h000_0000;
  logic fwd_clk;
  logic [LANES-1:0] lanes;
  logic [WORD_BITS-1:0] word;
  logic [WORD_BITS-1:0] held;
  logic strobe;
  logic ready;
  int err_total = 0;
  int n_checks = 0;

  // system clock and an unrelated link bit clock
  initial forever #5 sys_clk_in = ~sys_clk_in;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  lsd_deserializer #(.LOCK_CYCLES(LOCK_N)) i_lsd_deserializer (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .link_bit_clk_in(link_clk),
    .forwarded_link_clock_in(fwd_clk),
    .serial_lane_in(lanes),
    .lane_float_in(lane_float),
    .link_clock_float_in(clk_float),
    .sleep_request_n_in(sleep_n),
    .parallel_word_out(word),
    .parallel_strobe_clock_out(strobe),
    .lock_ready_out(ready)
  );

  lsd_tx_model i_lsd_tx_model (
    .bit_clk_in(link_clk),
    .word_in(tx_word),
    .frame_clk_out(fwd_clk),
    .lane_out(lanes)
  );

  // compare helpers
  task automatic chk_word(input logic [WORD_BITS-1:0] got,
                          input logic [WORD_BITS-1:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t word %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t flag %s got %b", $time, m, got);
    end
  endtask

  // wait for n rising strobe edges, bounded; word is read just after the last
  task automatic wait_strobe(input int n);
    int k;
    logic prev;
    k = 0;
    prev = strobe;
    while (n > 0 && k < 3000) begin
      @(negedge sys_clk_in);
      k++;
      if (strobe === 1'b1 && prev === 1'b0) n--;
      prev = strobe;
    end
    chk_bit(n == 0, 1'b1, "strobe edge");
  endtask

  task automatic t_wake();
    chk_word(word, 28'h000_0000, "asleep");
    @(negedge sys_clk_in);
    sleep_n = 1'b1;
    // no strobe while the lock timer runs
    repeat (LOCK_N) begin
      @(negedge sys_clk_in);
      chk_bit(strobe, 1'b0, "pre lock");
    end
    repeat (10) @(negedge sys_clk_in);
    chk_bit(ready, 1'b1, "locked");
  endtask

  task automatic t_words();
    logic [WORD_BITS-1:0] pat [5];
    pat = '{28'h000_0001, 28'h800_0000, 28'h555_5555, 28'hA5C_3F09,
            28'h000_007F};
    foreach (pat[i]) begin
      tx_word = pat[i];
      wait_strobe(3);
      chk_word(word, pat[i], "pattern");
      chk_word(word, pat[i], "order");
    end
  endtask

  task automatic t_rate();
    int c;
    logic prev;
    c = 0;
    prev = strobe;
    // ten frames of 336 ns give ten strobes
    repeat (336) begin
      @(negedge sys_clk_in);
      if (strobe === 1'b1 && prev === 1'b0) c++;
      prev = strobe;
    end
    chk_bit(c >= 9 && c <= 11, 1'b1, "one word a frame");
  endtask

  task automatic t_float();
    tx_word = 28'h000_0000;
    lane_float = 4'h4;
    wait_strobe(3);
    chk_word(word, 28'h01F_C000, "lane two float");
    lane_float = 4'hF;
    wait_strobe(3);
    chk_word(word, 28'hFFF_FFFF, "all float");
    held = word;
    clk_float = 1'b1;
    repeat (10) @(negedge sys_clk_in);
    repeat (100) begin
      @(negedge sys_clk_in);
      chk_bit(strobe, 1'b0, "clock float");
    end
    chk_word(word, held, "held");
    clk_float = 1'b0;
    lane_float = 4'h0;
    tx_word = 28'h123_4567;
    wait_strobe(3);
    chk_word(word, 28'h123_4567, "relock");
  endtask

  task automatic t_sleep();
    int k;
    sleep_n = 1'b0;
    k = 0;
    while ((word !== 28'h000_0000 || strobe !== 1'b0) && k < 100) begin
      @(negedge sys_clk_in);
      k++;
    end
    chk_bit(k < 100, 1'b1, "sleep entry");
    repeat (200) begin
      @(negedge sys_clk_in);
      chk_word(word, 28'h000_0000, "sleep low");
      chk_bit(strobe | ready, 1'b0, "sleep strobe");
    end
    sleep_n = 1'b1;
    wait_strobe(3);
    chk_word(word, 28'h123_4567, "wake");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a real falling edge on reset, so the link side resets with no link edge
  initial begin
    #1;
    reset_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    t_wake();
    t_words();
    t_rate();
    t_float();
    t_sleep();
    complete_run();
  end

  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    $display("[FAIL] %0t watchdog", $time);
    complete_run();
  end
endmodule
